/* File: xal_dir_if.sv */
// Carrier for a direction-register load from the decoder to the bank
`timescale 1ns/1ps
interface xal_dir_if;
  logic load;
  logic [2:0] sel;
  logic [7:0] data;
  modport src (output load, output sel, output data);
  modport dst (input load, input sel, input data);
endinterface : xal_dir_if

/* File: xal_dir_reg.sv */
// One port direction register, loaded when its own selector matches
`timescale 1ns/1ps
module xal_dir_reg #(
  parameter logic [2:0] SEL = 3'h5
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  xal_dir_if.dst ld,
  output logic [7:0] dir_o
);
  import xal_pkg::*;

  logic [7:0] next_dir;

  // Only a load aimed at this selector changes the value
  always_comb begin
    next_dir = dir_o;
    if (ld.load && ld.sel == SEL) begin
      next_dir = ld.data;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_o <= XAL_DIR_RST;
    end else begin
      dir_o <= next_dir;
    end
  end
endmodule : xal_dir_reg

/* File: xal_exec.sv */
// Decode and execute of direction-load, literal XOR and file XOR
// What this block does
// - Direction-load of 5, 6 or 7 copies the accumulator, flags unchanged.
// - Upper nine bits zero mark a direction-load; low three bits select.
// - Top nibble 1111 XORs the 8-bit literal into the accumulator.
// - Upper six bits 000110 XOR the accumulator with the addressed file.
// - File XOR destination bit 0 writes the accumulator, 1 the file.
`timescale 1ns/1ps
module xal_exec (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic instr_valid_i,
  input wire logic [xal_pkg::XAL_IW-1:0] instr_i,
  input wire logic [xal_pkg::XAL_DW-1:0] file_rdata_i,
  input wire logic acc_load_i,
  input wire logic [xal_pkg::XAL_DW-1:0] acc_load_data_i,
  output logic [xal_pkg::XAL_DW-1:0] acc_o,
  output logic zero_o,
  output logic file_we_o,
  output logic [xal_pkg::XAL_FAW-1:0] file_addr_o,
  output logic [xal_pkg::XAL_DW-1:0] file_wdata_o,
  output logic bad_dir_o,
  output logic [xal_pkg::XAL_DW-1:0] dir_a_o,
  output logic [xal_pkg::XAL_DW-1:0] dir_b_o,
  output logic [xal_pkg::XAL_DW-1:0] dir_c_o
);
  import xal_pkg::*;

  xal_dir_if dir_ld ();

  // Decode results, operand fields and the XOR datapath
  xal_op_t op;
  logic [2:0] dir_sel;
  logic dir_ok;
  logic dest;
  logic [7:0] x_opnd;
  logic [7:0] x_res;

  // Accumulator group
  logic [7:0] next_acc;
  logic next_zero;

  // File write-back group
  logic next_file_we;
  logic [4:0] next_file_addr;
  logic [7:0] next_file_wdata;

  // Direction-load group, registered before it reaches the bank
  logic next_bad_dir;
  logic next_dir_load;
  logic [2:0] next_dir_sel;
  logic [7:0] next_dir_data;
  logic dir_load;
  logic [2:0] dir_sel_q;
  logic [7:0] dir_data_q;

  // Classify the word; unknown encodings fall to no operation
  always_comb begin
    op = XAL_OP_NONE;
    if (instr_valid_i) begin
      if (instr_i[11:3] == XAL_DIR_OPC) begin
        op = XAL_OP_DIR;
      end else if (instr_i[11:8] == XAL_XLIT_OPC) begin
        op = XAL_OP_XLIT;
      end else if (instr_i[11:6] == XAL_XFILE_OPC) begin
        op = XAL_OP_XFILE;
      end
    end
  end

  // Operand fields
  assign dir_sel = instr_i[XAL_DIR_SEL_LSB +: 3];
  assign dir_ok = (dir_sel >= XAL_DIR_FIRST);
  assign dest = instr_i[XAL_DEST_BIT];

  // One XOR serves both forms; only its second operand is switched,
  // so the accumulator path needs no extra gate in front of it
  always_comb begin
    x_opnd = file_rdata_i;
    if (op == XAL_OP_XLIT) begin
      x_opnd = instr_i[XAL_XLIT_LSB +: 8];
    end
    x_res = acc_o ^ x_opnd;
  end

  // Accumulator and zero flag; every instruction retires here
  always_comb begin
    next_acc = acc_o;
    next_zero = zero_o;
    unique case (op)
      XAL_OP_NONE: begin
        // Side load only when no instruction owns the accumulator
        if (acc_load_i) begin
          next_acc = acc_load_data_i;
        end
      end
      XAL_OP_DIR: begin
        // A direction-load leaves accumulator and flag alone
        next_zero = zero_o;
      end
      XAL_OP_XLIT: begin
        next_acc = x_res;
        next_zero = (x_res == 8'h00);
      end
      XAL_OP_XFILE: begin
        next_zero = (x_res == 8'h00);
        if (dest == XAL_DEST_ACC) begin
          next_acc = x_res;
        end
      end
    endcase
  end

  // Accumulator registers; the outputs come straight from these flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_o <= XAL_ACC_RST;
      zero_o <= XAL_ZERO_RST;
    end else begin
      acc_o <= next_acc;
      zero_o <= next_zero;
    end
  end

  // File write-back; address and data hold after the strobe drops
  always_comb begin
    next_file_we = 1'b0;
    next_file_addr = file_addr_o;
    next_file_wdata = file_wdata_o;
    if (op == XAL_OP_XFILE && dest == XAL_DEST_FILE) begin
      next_file_we = 1'b1;
      next_file_addr = instr_i[4:0];
      next_file_wdata = x_res;
    end
  end

  // File port registers; the write strobe stands for one cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      file_we_o <= 1'b0;
      file_addr_o <= 5'h00;
      file_wdata_o <= 8'h00;
    end else begin
      file_we_o <= next_file_we;
      file_addr_o <= next_file_addr;
      file_wdata_o <= next_file_wdata;
    end
  end

  // Operands 0..4 are refused: no load, only a one-cycle flag
  always_comb begin
    next_bad_dir = 1'b0;
    next_dir_load = 1'b0;
    next_dir_sel = dir_sel_q;
    next_dir_data = dir_data_q;
    if (op == XAL_OP_DIR) begin
      if (dir_ok) begin
        next_dir_load = 1'b1;
        next_dir_sel = dir_sel;
        next_dir_data = acc_o;
      end else begin
        next_bad_dir = 1'b1;
      end
    end
  end

  // Registered load request and refusal flag
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bad_dir_o <= 1'b0;
      dir_load <= 1'b0;
      dir_sel_q <= 3'h0;
      dir_data_q <= 8'h00;
    end else begin
      bad_dir_o <= next_bad_dir;
      dir_load <= next_dir_load;
      dir_sel_q <= next_dir_sel;
      dir_data_q <= next_dir_data;
    end
  end

  // The bank sees a registered load; direction updates one edge after
  // the accumulator would, a latency traded for flop-driven outputs
  assign dir_ld.load = dir_load;
  assign dir_ld.sel = dir_sel_q;
  assign dir_ld.data = dir_data_q;

  // Direction register 5
  xal_dir_reg #(.SEL(3'h5)) u_dir_a (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .ld(dir_ld.dst),
    .dir_o(dir_a_o)
  );

  // Direction register 6
  xal_dir_reg #(.SEL(3'h6)) u_dir_b (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .ld(dir_ld.dst),
    .dir_o(dir_b_o)
  );

  // Direction register 7
  xal_dir_reg #(.SEL(3'h7)) u_dir_c (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .ld(dir_ld.dst),
    .dir_o(dir_c_o)
  );
endmodule : xal_exec

/* File: xal_exec_bench.sv */
// Self-checking bench for the XOR and direction-load block
`timescale 1ns/1ps
module xal_exec_bench;
  import xal_pkg::*;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [11:0] instr_i = 12'h000;
  logic [7:0] file_rdata_i = 8'h00;
  logic acc_load_i = 1'b0;
  logic [7:0] acc_load_data_i = 8'h00;
  logic [7:0] acc_o, file_wdata_o, dir_a_o, dir_b_o, dir_c_o;
  logic [4:0] file_addr_o;
  logic zero_o, file_we_o, bad_dir_o;
  int errors = 0;
  int tests_run = 0;
  // Rows: word, file value, then accumulator and zero expected
  logic [28:0] rows [6] = '{{12'hFB5, 8'h00, 8'hB5, 1'b0},
    {12'hFAF, 8'h00, 8'h1A, 1'b0}, {12'h183, 8'h1A, 8'h00, 1'b1},
    {12'hF00, 8'h00, 8'h00, 1'b1}, {12'h19F, 8'h3C, 8'h3C, 1'b0},
    {12'h0FF, 8'h55, 8'h3C, 1'b0}};
  always #5 clk_sys_i = ~clk_sys_i;
  xal_exec uut (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .file_rdata_i(file_rdata_i),
    .acc_load_i(acc_load_i),
    .acc_load_data_i(acc_load_data_i),
    .acc_o(acc_o),
    .zero_o(zero_o),
    .file_we_o(file_we_o),
    .file_addr_o(file_addr_o),
    .file_wdata_o(file_wdata_o),
    .bad_dir_o(bad_dir_o),
    .dir_a_o(dir_a_o),
    .dir_b_o(dir_b_o),
    .dir_c_o(dir_c_o)
  );
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  // Inputs change only at a rising edge; side load reuses the file value
  task go(input logic [11:0] w, input logic [7:0] r, input logic v,
          input logic l);
    @(posedge clk_sys_i);
    instr_i <= w;
    file_rdata_i <= r;
    acc_load_data_i <= r;
    instr_valid_i <= v;
    acc_load_i <= l;
  endtask : go
  // One word, then the idle edge that takes it, settled for checking
  task run(input logic [11:0] w, input logic [7:0] r);
    go(w, r, 1'b1, 1'b0);
    go(12'h000, 8'h00, 1'b0, 1'b0);
    #1;
  endtask : run
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // Watchdog, far beyond the few hundred nanoseconds the tests need
  initial begin
    #20000;
    errors++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    #1;
    chk(dir_a_o, XAL_DIR_RST);
    for (int i = 0; i < 6; i++) begin
      run(rows[i][28:17], rows[i][16:9]);
      chk(acc_o, rows[i][8:1]);
      chk({7'h00, zero_o}, {7'h00, rows[i][0]});
    end
    $display("table done");
    run(12'h1A3, 8'hAF);
    chk({file_we_o, 2'h0, file_addr_o}, 8'h83);
    chk(file_wdata_o, 8'h93);
    chk(acc_o, 8'h3C);
    $display("file write done");
    // Back to back: the load must copy the freshly XORed value
    go(12'hF99, 8'h00, 1'b1, 1'b0);
    go(12'h006, 8'h00, 1'b1, 1'b0);
    run(12'h004, 8'h00);
    chk({7'h00, bad_dir_o}, 8'h01);
    chk(dir_b_o, 8'hA5);
    chk(dir_a_o, XAL_DIR_RST);
    run(12'h005, 8'h00);
    run(12'h007, 8'h00);
    @(posedge clk_sys_i);
    #1;
    chk(dir_a_o, 8'hA5);
    chk(dir_c_o, 8'hA5);
    $display("direction load done");
    // Side load only lands in a cycle without an instruction
    go(12'h000, 8'h42, 1'b0, 1'b1);
    go(12'hF01, 8'h00, 1'b1, 1'b1);
    run(12'h000, 8'h00);
    chk(acc_o, 8'h43);
    // Mid-run reset, accumulator, direction register 6 and file port checked, then released
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    #1;
    chk(acc_o, XAL_ACC_RST);
    chk(dir_b_o, XAL_DIR_RST);
    chk({file_we_o, 2'h0, file_addr_o}, 8'h00);
    chk(file_wdata_o, 8'h00);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    run(12'hF5A, 8'h00);
    chk(acc_o, 8'h5A);
    chk({7'h00, zero_o}, 8'h00);
    $display("reset done");
    wrap_up;
  end
endmodule : xal_exec_bench

/* File: xal_exec_chk.sv */
// Port checker for the XOR and direction-load block
`timescale 1ns/1ps
module xal_exec_chk (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic instr_valid_i,
  input wire logic [11:0] instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] acc_o,
  input wire logic zero_o,
  input wire logic file_we_o,
  input wire logic [4:0] file_addr_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic bad_dir_o,
  input wire logic [7:0] dir_b_o
);
  // Decode of the word taken at this edge, in priority order
  wire dl = instr_valid_i && instr_i[11:3] == 9'h000;
  wire lit = instr_valid_i && instr_i[11:8] == 4'hF;
  wire fx = instr_valid_i && instr_i[11:6] == 6'h06;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_lit_xor: assert property (
    lit |=> acc_o == ($past(acc_o) ^ $past(instr_i[7:0])))
    else $error("literal xor result wrong");
  a_lit_zero: assert property (
    lit |=> zero_o == (acc_o == 8'h00)) else $error("zero flag wrong");
  a_file_wr: assert property (
    fx && instr_i[5] |=> file_we_o && $stable(acc_o) &&
    file_addr_o == $past(instr_i[4:0]) &&
    file_wdata_o == ($past(acc_o) ^ $past(file_rdata_i)))
    else $error("file write-back wrong");
  a_file_acc: assert property (
    fx && !instr_i[5] |=> !file_we_o &&
    acc_o == ($past(acc_o) ^ $past(file_rdata_i)))
    else $error("file xor into accumulator wrong");
  a_dir_copy: assert property (
    dl && instr_i[2:0] == 3'h6 |=> ##1 dir_b_o == $past(acc_o, 2))
    else $error("direction load wrong");
  a_dir_flags: assert property (
    dl |=> $stable(zero_o)) else $error("direction load moved zero");
  a_bad_dir: assert property (
    dl && instr_i[2:0] < 3'h5 |=> bad_dir_o && $stable(acc_o))
    else $error("bad operand not flagged");
  a_we_cause: assert property (
    !fx |=> !file_we_o) else $error("stray file write");
  a_file_zero: assert property (
    fx |=> zero_o == (($past(acc_o) ^ $past(file_rdata_i)) == 8'h00))
    else $error("file xor zero flag wrong");
  a_bad_cause: assert property (
    !(dl && instr_i[2:0] < 3'h5) |=> !bad_dir_o)
    else $error("stray bad operand flag");
endmodule : xal_exec_chk

bind xal_exec xal_exec_chk u_chk (
  .clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i),
  .instr_valid_i(instr_valid_i),
  .instr_i(instr_i),
  .file_rdata_i(file_rdata_i),
  .acc_o(acc_o),
  .zero_o(zero_o),
  .file_we_o(file_we_o),
  .file_addr_o(file_addr_o),
  .file_wdata_o(file_wdata_o),
  .bad_dir_o(bad_dir_o),
  .dir_b_o(dir_b_o)
);

/* File: xal_pkg.sv */
// Shared constants for the XOR and direction-load execute block
package xal_pkg;
  localparam int XAL_IW = 12;
  localparam int XAL_DW = 8;
  localparam int XAL_FAW = 5;
  // Direction-load: upper nine bits zero, low three bits select
  localparam logic [8:0] XAL_DIR_OPC = 9'h000;
  localparam int XAL_DIR_SEL_LSB = 0;
  localparam logic [2:0] XAL_DIR_FIRST = 3'h5;
  localparam int XAL_DIR_COUNT = 3;
  // Literal XOR: top nibble 1111
  localparam logic [3:0] XAL_XLIT_OPC = 4'hF;
  localparam int XAL_XLIT_LSB = 0;
  // File XOR: upper six bits 0001 10, d at bit 5, f at bits 4..0
  localparam logic [5:0] XAL_XFILE_OPC = 6'h06;
  localparam int XAL_DEST_BIT = 5;
  localparam logic XAL_DEST_ACC = 1'b0;
  localparam logic XAL_DEST_FILE = 1'b1;
  // Values after reset
  localparam logic [7:0] XAL_ACC_RST = 8'h00;
  localparam logic XAL_ZERO_RST = 1'b0;
  localparam logic [7:0] XAL_DIR_RST = 8'hFF;
  // Instruction classes
  typedef enum logic [1:0] {
    XAL_OP_NONE = 2'b00,
    XAL_OP_DIR = 2'b01,
    XAL_OP_XLIT = 2'b10,
    XAL_OP_XFILE = 2'b11
  } xal_op_t;
endpackage : xal_pkg
